// ==== common/sat_defines.svh ====
// register offsets, field positions and reset values of the slope converter core
// assumes a 32-bit apb slave with one aligned word per register
`ifndef SAT_DEFINES_SVH
`define SAT_DEFINES_SVH

`define SAT_OFF_CTRL_A     12'h000
`define SAT_OFF_CTRL_B     12'h004
`define SAT_OFF_POWER      12'h008
`define SAT_OFF_CNT_HIGH   12'h00c
`define SAT_OFF_CNT_LOW    12'h010
`define SAT_OFF_CAP_HIGH   12'h014
`define SAT_OFF_CAP_LOW    12'h018
`define SAT_OFF_STATUS     12'h01c
`define SAT_OFF_IRQ_CTRL   12'h020

`define SAT_ADDR_MSB       11
`define SAT_ADDR_LSB       2

`define SAT_CTRL_A_RST     8'h02
`define SAT_CTRL_A_MASK    8'hf7
`define SAT_CTRL_B_RST     8'h00
`define SAT_POWER_RST      8'h3f
`define SAT_POWER_MASK     8'hbf
`define SAT_IRQ_CTRL_RST   8'h00

`define SAT_BIT_ZERO       0
`define SAT_BIT_RAMP_RST   1
`define SAT_BIT_MUX_OE     2
`define SAT_BIT_CONV_OFF   0
`define SAT_BIT_OSC_OFF    3
`define SAT_BIT_REF_OFF    5
`define SAT_BIT_CAP_FLAG   0
`define SAT_BIT_OVF_FLAG   1
`define SAT_BIT_CAP_IE     0
`define SAT_BIT_OVF_IE     1
`define SAT_BIT_PERIPH_IE  2
`define SAT_BIT_GLOBAL_IE  3
`define SAT_BIT_EXT_OSC    4

`define SAT_CNT_ZERO       16'h0000
`define SAT_CNT_MAX        16'hffff
`define SAT_CNT_ONE        16'h0001

`endif

// ==== common/sat_pkg.sv ====
// types of the slope converter core
// assumes sat_defines.svh carries every numeric constant
package sat_pkg;

    typedef struct packed {
        logic [7:0]  ctrl_a;
        logic [7:0]  ctrl_b;
        logic [7:0]  power;
        logic [7:0]  irq_ctrl;
        logic [15:0] count;
        logic [15:0] capture;
        logic        cap_flag;
        logic        ovf_flag;
        logic        high_written;
        logic        run_ok;
        logic        cap_done;
        logic [1:0]  cmp_sync;
        logic [1:0]  ext_sync;
        logic        cmp_prev;
        logic        ext_prev;
        logic        pending_trip;
        logic        cap_irq;
        logic        ovf_irq;
        logic [31:0] prdata;
        logic        pslverr;
        logic        ready;
        logic [3:0]  channel;
        logic [3:0]  current;
        logic        src_connect;
        logic        discharge;
        logic        conv_power;
        logic        ref_power;
        logic        mux_oe;
        logic        zero_en;
        logic        analog_pins;
    } sat_state_t;

endpackage

// ==== rtl/sat_core.sv ====
// slope converter digital core: ramp timer, trip capture, flags, apb registers
// assumes comparator, external osc and sleep request are async; apb on pclk
// register map, one byte at the low end of each word
//   ctrl_a   : channel select 7:4, mux out enable 2, ramp reset 1, zero 0
//   ctrl_b   : current select 7:4; the low nibble is stored only
//   power    : reference off 5, sleep osc off 3, converter off 0; bit 6 reads 0
//   count    : high and low byte of the ramp timer
//   capture  : high and low byte of the trip capture
//   status   : capture flag 0, overflow flag 1; write one to clear
//   irq_ctrl : capture ie 0, overflow ie 1, peripheral ie 2, global ie 3,
//              external oscillator select 4
//   other offsets: writes are dropped, reads give zero, pslverr is raised
//
// clocking
//   everything runs on pclk; the external oscillator only makes tick pulses,
//   so each of its levels must last a full pclk cycle to be seen.
//
// reset
//   presetn clears the timer and capture, leaves ramp reset set so the
//   capacitor discharges, and powers the converter and references down.
//   the shared pins report analog use from the first cycle on.
//
// bus timing
//   every access has one wait state: the first access cycle decodes and
//   registers read data and error, the second shows them with pready, and
//   a write lands at that second edge. data from a flop keeps the read path
//   short; the price is one cycle per access.
//   pready is low outside that second access cycle.
//
// analog timing
//   comparator and external oscillator pass two flops and an edge detector,
//   so a trip is captured two to three cycles after the pin falls; the
//   value taken is the count at that moment.
//   current source, discharge and power controls follow their register bits
//   one cycle after the write lands.
//
// limitations
//   a low byte written without a high byte first stops the timer until a
//   proper high then low pair arrives.
//   the timer has no shadow latch: a read while counting may see the two
//   bytes from different counts.
//   with the oscillator off in sleep the count freezes; a trip meanwhile is
//   remembered and captured at wake, and that value means nothing.
//   only one capture per conversion; raising ramp reset arms the next one.
//   a flag clear that meets a hardware set in the same cycle loses.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "sat_defines.svh"

module sat_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave side
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // asynchronous levels from the analog side and the core
    input  wire logic        cmp_out,
    input  wire logic        ext_osc,
    input  wire logic        sleep_req,
    // analog controls, each a level straight from a flop
    output logic [3:0]       channel_select,
    output logic [3:0]       current_select,
    output logic             src_connect,
    output logic             ramp_discharge,
    output logic             converter_power,
    output logic             reference_power,
    output logic             mux_out_enable,
    output logic             zero_enable,
    output logic             analog_pins,
    // interrupt requests
    output logic             capture_irq,
    output logic             overflow_irq
);

    sat_pkg::sat_state_t s_q;
    sat_pkg::sat_state_t s_d;
    logic [1:0]          slp_sync_q;

    // =====================================================================
    // helpers
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[`SAT_ADDR_MSB:`SAT_ADDR_LSB] == off[`SAT_ADDR_MSB:`SAT_ADDR_LSB]);
    endfunction

    function automatic logic [31:0] word8(input logic [7:0] v);
        word8 = {24'h000000, v};
    endfunction

    // any offset that decodes to a register
    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, `SAT_OFF_CTRL_A)   ||
                 hit(a, `SAT_OFF_CTRL_B)   ||
                 hit(a, `SAT_OFF_POWER)    ||
                 hit(a, `SAT_OFF_CNT_HIGH) ||
                 hit(a, `SAT_OFF_CNT_LOW)  ||
                 hit(a, `SAT_OFF_CAP_HIGH) ||
                 hit(a, `SAT_OFF_CAP_LOW)  ||
                 hit(a, `SAT_OFF_STATUS)   ||
                 hit(a, `SAT_OFF_IRQ_CTRL);
    endfunction

    // one-cycle pulses on a rise or a fall of a synchronised level
    function automatic logic rose_now(input logic prev, input logic now);
        rose_now = now && !prev;
    endfunction

    function automatic logic fell_now(input logic prev, input logic now);
        fell_now = prev && !now;
    endfunction

    // a request needs its flag and all three enables
    function automatic logic gated(input logic flag, input logic ie,
                                   input logic pe, input logic ge);
        gated = flag && ie && pe && ge;
    endfunction

    // sleep request is a level from another domain; two flops stand before
    // the clock stop logic reads it, so a late request costs at most two
    // cycles of counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slp_sync_q <= 2'h0;
        end else begin
            slp_sync_q <= {slp_sync_q[0], sleep_req};
        end
    end

    // =====================================================================
    // next state
    always_comb begin
        logic acc;
        logic wr;
        logic rd;
        logic ramp_rst;
        logic clk_gone;
        logic tick;
        logic trip;
        logic [15:0] cnt;
        logic ge;
        logic pe;
        logic first;
        logic cap_set;
        logic ovf_set;
        // every local starts cleared so no path leaves a latch
        acc      = 1'b0;
        first    = 1'b0;
        cap_set  = 1'b0;
        ovf_set  = 1'b0;
        wr       = 1'b0;
        rd       = 1'b0;
        ramp_rst = 1'b0;
        clk_gone = 1'b0;
        tick     = 1'b0;
        trip     = 1'b0;
        cnt      = 16'h0000;
        ge       = 1'b0;
        pe       = 1'b0;
        s_d      = s_q;

        // =================================================================
        // bus handshake
        // the first access cycle decodes, the second completes with pready
        acc       = psel && penable;
        first     = acc && !s_q.ready;
        s_d.ready = first;
        wr        = acc && s_q.ready && pwrite;
        rd        = first && !pwrite;

        // =================================================================
        // synchronisers, only the second stage feeds logic
        s_d.cmp_sync = {s_q.cmp_sync[0], cmp_out};
        s_d.ext_sync = {s_q.ext_sync[0], ext_osc};
        s_d.cmp_prev = s_q.cmp_sync[1];
        s_d.ext_prev = s_q.ext_sync[1];

        ramp_rst = s_q.ctrl_a[`SAT_BIT_RAMP_RST];
        // sleep with oscillator off stops the converter clock
        clk_gone = slp_sync_q[1] && s_q.power[`SAT_BIT_OSC_OFF];

        // =================================================================
        // tick source: every pclk or a rise of the synced external oscillator
        if (s_q.irq_ctrl[`SAT_BIT_EXT_OSC]) begin
            tick = rose_now(s_q.ext_prev, s_q.ext_sync[1]);
        end else begin
            tick = 1'b1;
        end

        // falling edge of synced comparator
        trip = fell_now(s_q.cmp_prev, s_q.cmp_sync[1]);

        // =================================================================
        // timer and capture; a trip while the clock is stopped waits for wake
        if (clk_gone) begin
            if (trip) begin
                s_d.pending_trip = 1'b1;
            end
        end else begin
            cnt = s_q.count;
            if (!ramp_rst && s_q.run_ok && tick) begin
                cnt = s_q.count + `SAT_CNT_ONE;
                if (s_q.count == `SAT_CNT_MAX) begin
                    s_d.ovf_flag = 1'b1;
                    ovf_set      = 1'b1;
                end
            end
            s_d.count = cnt;
            if ((trip || s_q.pending_trip) && !s_q.cap_done) begin
                s_d.capture      = s_q.count;
                s_d.cap_flag     = 1'b1;
                cap_set          = 1'b1;
                s_d.cap_done     = 1'b1;
                s_d.pending_trip = 1'b0;
            end
        end
        // a new conversion cycle starts when ramp reset is asserted
        if (ramp_rst) begin
            s_d.cap_done     = 1'b0;
            s_d.pending_trip = 1'b0;
        end

        // =================================================================
        // register writes; a hardware set in the same cycle beats a clear
        s_d.pslverr = first && !mapped(paddr);
        if (wr) begin
            if (hit(paddr, `SAT_OFF_CTRL_A)) begin
                s_d.ctrl_a = pwdata[7:0] & `SAT_CTRL_A_MASK;
            end else if (hit(paddr, `SAT_OFF_CTRL_B)) begin
                s_d.ctrl_b = pwdata[7:0];
            end else if (hit(paddr, `SAT_OFF_POWER)) begin
                s_d.power = pwdata[7:0] & `SAT_POWER_MASK;
            end else if (hit(paddr, `SAT_OFF_CNT_HIGH)) begin
                s_d.count[15:8]  = pwdata[7:0];
                s_d.high_written = 1'b1;
                s_d.run_ok       = 1'b0;
            end else if (hit(paddr, `SAT_OFF_CNT_LOW)) begin
                s_d.count[7:0]   = pwdata[7:0];
                s_d.run_ok       = s_q.high_written;
                s_d.high_written = 1'b0;
            end else if (hit(paddr, `SAT_OFF_CAP_HIGH)) begin
                s_d.capture[15:8] = pwdata[7:0];
            end else if (hit(paddr, `SAT_OFF_CAP_LOW)) begin
                s_d.capture[7:0] = pwdata[7:0];
            end else if (hit(paddr, `SAT_OFF_STATUS)) begin
                // write one to clear
                if (pwdata[`SAT_BIT_CAP_FLAG] && !cap_set) begin
                    s_d.cap_flag = 1'b0;
                end
                if (pwdata[`SAT_BIT_OVF_FLAG] && !ovf_set) begin
                    s_d.ovf_flag = 1'b0;
                end
            end else if (hit(paddr, `SAT_OFF_IRQ_CTRL)) begin
                s_d.irq_ctrl = pwdata[7:0];
            end
        end

        // =================================================================
        // register reads, data registered in the first access cycle
        s_d.prdata = 32'h00000000;
        if (rd) begin
            if (hit(paddr, `SAT_OFF_CTRL_A)) begin
                s_d.prdata = word8(s_q.ctrl_a);
            end else if (hit(paddr, `SAT_OFF_CTRL_B)) begin
                s_d.prdata = word8(s_q.ctrl_b);
            end else if (hit(paddr, `SAT_OFF_POWER)) begin
                s_d.prdata = word8(s_q.power);
            end else if (hit(paddr, `SAT_OFF_CNT_HIGH)) begin
                s_d.prdata = word8(s_q.count[15:8]);
            end else if (hit(paddr, `SAT_OFF_CNT_LOW)) begin
                s_d.prdata = word8(s_q.count[7:0]);
            end else if (hit(paddr, `SAT_OFF_CAP_HIGH)) begin
                s_d.prdata = word8(s_q.capture[15:8]);
            end else if (hit(paddr, `SAT_OFF_CAP_LOW)) begin
                s_d.prdata = word8(s_q.capture[7:0]);
            end else if (hit(paddr, `SAT_OFF_STATUS)) begin
                s_d.prdata = {30'h00000000, s_q.ovf_flag, s_q.cap_flag};
            end else if (hit(paddr, `SAT_OFF_IRQ_CTRL)) begin
                s_d.prdata = word8(s_q.irq_ctrl);
            end
        end

        // =================================================================
        // interrupt requests, gated by the three enables
        ge = s_q.irq_ctrl[`SAT_BIT_GLOBAL_IE];
        pe = s_q.irq_ctrl[`SAT_BIT_PERIPH_IE];
        s_d.cap_irq = gated(s_q.cap_flag, s_q.irq_ctrl[`SAT_BIT_CAP_IE], pe, ge);
        s_d.ovf_irq = gated(s_q.ovf_flag, s_q.irq_ctrl[`SAT_BIT_OVF_IE], pe, ge);

        // =================================================================
        // analog controls
        s_d.channel     = s_q.ctrl_a[7:4];
        s_d.current     = s_q.ctrl_b[7:4];
        s_d.src_connect = !ramp_rst && !s_q.power[`SAT_BIT_CONV_OFF];
        s_d.discharge   = ramp_rst;
        s_d.conv_power  = !s_q.power[`SAT_BIT_CONV_OFF];
        s_d.ref_power   = !s_q.power[`SAT_BIT_REF_OFF];
        s_d.mux_oe      = s_q.ctrl_a[`SAT_BIT_MUX_OE];
        s_d.zero_en     = s_q.ctrl_a[`SAT_BIT_ZERO];
        // digital pin use is outside this block: pins stay analog
        s_d.analog_pins = 1'b1;
    end

    // =====================================================================
    // state register
    // reset leaves the converter off, the capacitor discharging, the pins
    // analog and the timer at zero; everything else except run_ok, the ramp reset bit of ctrl_a and the power register starts cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q              <= '0;
            s_q.ctrl_a       <= `SAT_CTRL_A_RST;
            s_q.ctrl_b       <= `SAT_CTRL_B_RST;
            s_q.power        <= `SAT_POWER_RST;
            s_q.irq_ctrl     <= `SAT_IRQ_CTRL_RST;
            s_q.count        <= `SAT_CNT_ZERO;
            s_q.run_ok       <= 1'b1;
            s_q.discharge    <= 1'b1;
            s_q.analog_pins  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // =====================================================================
    // outputs, each straight from the state flops
    // pready is a flop too, so no output has a combinational path from the
    // bus inputs
    assign pready          = s_q.ready;
    assign prdata          = s_q.prdata;
    assign pslverr         = s_q.pslverr;
    assign channel_select  = s_q.channel;
    assign current_select  = s_q.current;
    assign src_connect     = s_q.src_connect;
    assign ramp_discharge  = s_q.discharge;
    assign converter_power = s_q.conv_power;
    assign reference_power = s_q.ref_power;
    assign mux_out_enable  = s_q.mux_oe;
    assign zero_enable     = s_q.zero_en;
    assign analog_pins     = s_q.analog_pins;
    assign capture_irq     = s_q.cap_irq;
    assign overflow_irq    = s_q.ovf_irq;

endmodule // sat_core

// ==== tb/sat_core_properties.sv ====
// port assertions of the slope converter core
// assumes one pclk domain; bound into every sat_core instance below
`timescale 1ns/1ps
`include "sat_defines.svh"
module sat_core_properties (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic        pready,
    input logic [31:0] prdata,
    input logic        pslverr,
    input logic [3:0]  channel_select,
    input logic [3:0]  current_select,
    input logic        ramp_discharge,
    input logic        converter_power,
    input logic        analog_pins,
    input logic        capture_irq,
    input logic        overflow_irq
);
    logic acc;
    logic wr;
    assign acc = psel && penable;
    assign wr  = acc && pwrite && pready;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // bus answers
    a_ready_wait: assert property (acc && !pready |=> pready)
        else $error("pready missing after the wait state");
    a_rdata_idle: assert property (!acc |=> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside an answer");
    a_hole_err: assert property (acc && !pready && paddr > `SAT_OFF_IRQ_CTRL |=>
        pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    // ==========================================
    // fields reach the pins at most two edges after the write
    a_chan_field: assert property (wr && paddr == `SAT_OFF_CTRL_A |->
        ##2 channel_select == $past(pwdata[7:4], 2)) else $error("channel select not taken");
    a_curr_field: assert property (wr && paddr == `SAT_OFF_CTRL_B |->
        ##2 current_select == $past(pwdata[7:4], 2)) else $error("current select not taken");
    a_ramp_hold: assert property (wr && paddr == `SAT_OFF_CTRL_A |->
        ##2 ramp_discharge == $past(pwdata[1], 2)) else $error("discharge not following");
    a_reset_state: assert property ($rose(presetn) |-> ramp_discharge &&
        !converter_power && analog_pins && !capture_irq && !overflow_irq)
        else $error("not in lowest current state after reset");
    // flags only go away through a bus write, so a quiet bus keeps the request
    a_cap_sticky: assert property (capture_irq && !acc && !$past(acc) |=> capture_irq)
        else $error("capture request cleared without software");
    c_capture: cover property (capture_irq);
    c_overflow: cover property (overflow_irq);
    c_hole: cover property (wr && paddr > `SAT_OFF_IRQ_CTRL);
endmodule // sat_core_properties
bind sat_core sat_core_properties u_props (.*);

// ==== tb/sat_ramp_model.sv ====
// ramp capacitor and comparator at the far side of the core
// assumes one ramp step per pclk while the current source is connected
`timescale 1ns/1ps
module sat_ramp_model (
    input logic  pclk,
    input logic  src_connect,
    input logic  ramp_discharge,
    input int    trip_level,
    output logic cmp_out
);
    int level = 0;
    // ==========================================
    // ramp
    always @(posedge pclk) begin
        if (ramp_discharge)
            level <= 0;
        else if (src_connect)
            level <= level + 1;
    end
    // raising trip_level mid-run makes the comparator rise and fall again
    assign cmp_out = level < trip_level;
endmodule // sat_ramp_model

// ==== tb/test_slope_adc_timer_capture.sv ====
// self-checking bench of the slope converter core
// assumes the ramp model plays comparator and capacitor
`timescale 1ns/1ps
`include "sat_defines.svh"
module test_slope_adc_timer_capture;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, ext_osc = 1'b0, sleep_req = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, cmp_out, src_connect, ramp_discharge, er;
    logic        converter_power, reference_power, mux_out_enable, zero_enable;
    logic        analog_pins, capture_irq, overflow_irq;
    logic [3:0]  channel_select, current_select;
    logic [15:0] s, cap, cnt;
    logic [23:0] v;
    logic [7:0]  mdl [int];
    logic [19:0] rv [7] = '{20'h00002, 20'h00400, 20'h0083f, 20'h00c00, 20'h01000,
                            20'h01c00, 20'h02000};
    int          fail_count = 0, total_checks = 0, trip = 1000000, t;

    always #5 pclk = ~pclk;
    always @(posedge pclk) ext_osc <= ext_osc ^ ($urandom_range(3) == 0);

    sat_core dut (.*);
    sat_ramp_model u_ramp (.pclk(pclk), .src_connect(src_connect),
        .ramp_discharge(ramp_discharge), .trip_level(trip), .cmp_out(cmp_out));
    // ==========================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // read data and error are taken at the edge that sees pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w) mdl[a] = d;
    endtask
    task automatic rd16(input logic [11:0] a, output logic [15:0] r);
        apb(1'b0, a, 8'h00);
        r[15:8] = rd[7:0];
        apb(1'b0, a + 12'h004, 8'h00);
        r[7:0] = rd[7:0];
    endtask
    task automatic wait_st(input int b);
        do apb(1'b0, `SAT_OFF_STATUS, 8'h00); while (rd[b] !== 1'b1);
    endtask
    task automatic conv(input logic [7:0] ie, input logic [15:0] st, input int tr);
        apb(1'b1, `SAT_OFF_CTRL_A, 8'h02);
        apb(1'b1, `SAT_OFF_STATUS, 8'h03);
        apb(1'b1, `SAT_OFF_IRQ_CTRL, ie);
        apb(1'b1, `SAT_OFF_CNT_HIGH, st[15:8]);
        apb(1'b1, `SAT_OFF_CNT_LOW, st[7:0]);
        trip = tr;
        apb(1'b1, `SAT_OFF_CTRL_A, 8'h00);
    endtask
    task automatic give_verdict;
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========================================
    // tests
    initial begin
        t = $urandom(32'hcd924206);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rv[i]) begin
            apb(1'b0, rv[i][19:8], 8'h00);
            chk("reset_value", {24'h0, rv[i][7:0]}, rd);
        end
        apb(1'b1, 12'h024, 8'h55);
        chk("hole_err", 1, er);
        apb(1'b0, 12'h024, 8'h00);
        chk("hole_data", 0, rd);
        apb(1'b1, `SAT_OFF_POWER, 8'h00);
        apb(1'b1, `SAT_OFF_CNT_LOW, 8'h10);
        apb(1'b1, `SAT_OFF_CTRL_A, 8'h00);
        repeat (50) @(posedge pclk);
        rd16(`SAT_OFF_CNT_HIGH, cnt);
        chk("lone_low_write", 16'h0010, cnt);
        repeat (4) begin
            v = $urandom;
            apb(1'b1, `SAT_OFF_CTRL_A, v[7:0] | 8'h02);
            apb(1'b1, `SAT_OFF_CTRL_B, {v[11:8], 4'h0});
            apb(1'b1, `SAT_OFF_POWER, v[23:16] & 8'h21);
            repeat (2) @(posedge pclk);
            chk("ref_power", !v[21], reference_power);
            chk("mux_oe", mdl[0][2], mux_out_enable);
            chk("zero_en", mdl[0][0], zero_enable);
            chk("src_connect", 0, src_connect);
            chk("discharge", 1, ramp_discharge);
            chk("channel", mdl[0][7:4], channel_select);
            chk("current", v[11:8], current_select);
            chk("conv_power", !v[16], converter_power);
            apb(1'b0, `SAT_OFF_CTRL_A, 8'h00);
            chk("ctrl_a", mdl[0] & 8'hf7, rd);
        end
        apb(1'b1, `SAT_OFF_POWER, 8'h00);
        for (int i = 0; i < 16; i++) begin
            s = 16'($urandom_range(16'hf000));
            t = $urandom_range(200, 20);
            conv(8'(i), s, t);
            wait_st(0);
            chk("capture_irq", i[0] & i[2] & i[3], capture_irq);
            chk("overflow_irq", 0, overflow_irq);
            rd16(`SAT_OFF_CAP_HIGH, cap);
            rd16(`SAT_OFF_CNT_HIGH, cnt);
            chk("capture_window", 1, (int'(cap) - int'(s) - t) inside {[-2:8]});
            chk("still_counting", 1, cnt > cap);
            apb(1'b1, `SAT_OFF_STATUS, 8'h01);
            trip = t + 100;
            repeat (200) @(posedge pclk);
            apb(1'b0, `SAT_OFF_STATUS, 8'h00);
            chk("second_capture", 0, rd[0]);
        end
        for (int j = 0; j < 2; j++) begin
            conv(j ? 8'h17 : 8'h1f, 16'hffd8, 1000000);
            wait_st(1);
            chk("overflow_irq", j == 0, overflow_irq);
            rd16(`SAT_OFF_CNT_HIGH, cnt);
            chk("wrapped_count", 0, cnt[15:8]);
        end
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `SAT_OFF_POWER, k ? 8'h08 : 8'h00);
            conv(8'h0f, 16'h0100, 30);
            sleep_req <= 1'b1;
            repeat (100) @(posedge pclk);
            apb(1'b0, `SAT_OFF_STATUS, 8'h00);
            chk("capture_in_sleep", k == 0, rd[0]);
            sleep_req <= 1'b0;
            wait_st(0);
            chk("irq_after_wake", 1, capture_irq);
        end
        give_verdict;
    end
    // a hung handshake or flag poll ends here
    initial begin
        #1000000;
        fail_count++;
        give_verdict;
    end
endmodule // test_slope_adc_timer_capture
